// *** logic/monitor_regs_consts.svh ***
// Offsets, field positions, widths and reset values of the monitor control, threshold and result registers
`ifndef MONITOR_REGS_CONSTS_SVH
`define MONITOR_REGS_CONSTS_SVH

`define OFS_CTRL          8'h08
`define OFS_PWM_UPPER     8'h09
`define OFS_RESULT_BASE   8'h0A
`define NUM_RESULT_SLOTS  10
`define RES_W             14
`define SLOT_IDX_W        4
`define CTRL_RESET        8'h00
`define PWM_UPPER_RESET   8'h00
`define CTRL_RW_MASK      8'hFC
`define BIT_FRESH         7
`define BIT_SIGN          6
`define BIT_PWM_LSB       7
`define NARROW_TOP        12

`endif

// *** logic/monitor_regs_pkg.sv ***
// Types shared by the monitor result register bank
`include "monitor_regs_consts.svh"

package monitor_regs_pkg;

  // One finished conversion delivered by the converter
  typedef struct packed {
    logic                     valid;
    logic [`SLOT_IDX_W-1:0]   slot;
    logic                     voltage;
    logic                     sign;
    logic [`RES_W-1:0]        data;
  } conv_in_t;

  // One register access from the serial engine
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic              fresh;
    logic              voltage;
    logic              sign;
    logic [`RES_W-1:0] data;
  } slot_state_t;

  typedef struct packed {
    logic [7:0]             ctrl;
    logic [7:0]             pwm_upper;
    logic [7:0]             rd_data;
    logic                   rd_valid;
    logic [7:0]             lo_shadow;
    logic [`SLOT_IDX_W-1:0] shadow_slot;
    logic                   shadow_ok;
  } top_state_t;

endpackage

// *** logic/result_slot.sv ***
// One result register pair: fresh flag, sign and data, packed as high and low byte
`include "monitor_regs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module result_slot (
  input  wire logic              mclk,          // System clock
  input  wire logic              rst,           // Async reset, active high
  input  wire logic              load,          // New result stored this cycle
  input  wire logic              load_voltage,  // Result uses voltage layout
  input  wire logic              load_sign,     // Sign of new result
  input  wire logic [`RES_W-1:0] load_data,     // Magnitude bits of new result
  input  wire logic              rd_hi,         // Host reads the high byte
  output logic      [7:0]        hi_byte,       // High byte view
  output logic      [7:0]        lo_byte        // Low byte view
);

  monitor_regs_pkg::slot_state_t s_r;
  monitor_regs_pkg::slot_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (rd_hi) begin
      s_nxt.fresh = 1'b0; // RULE_04
    end
    if (load) begin
      s_nxt.fresh   = 1'b1; // RULE_03
      s_nxt.voltage = load_voltage;
      s_nxt.sign    = load_sign;
      s_nxt.data    = load_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Voltage: sign plus 14 bits; temperature and diode: 13 bits, two unused
  always_comb begin
    if (s_r.voltage) begin
      hi_byte = {s_r.fresh, s_r.sign, s_r.data[13:8]}; // RULE_11 RULE_06 RULE_07 RULE_08
    end else begin
      hi_byte = {s_r.fresh, 2'b00, s_r.data[`NARROW_TOP:8]}; // RULE_01 RULE_09 RULE_10
    end
    lo_byte = s_r.data[7:0]; // RULE_02
  end

  property p_fresh_set;
    @(posedge mclk) disable iff (rst) load |=> hi_byte[`BIT_FRESH];
  endproperty
  a_fresh_set: assert property (p_fresh_set) // RULE_03
    else $error("fresh flag not set after new result");

  property p_fresh_clear;
    @(posedge mclk) disable iff (rst) (rd_hi && !load) |=> !hi_byte[`BIT_FRESH];
  endproperty
  a_fresh_clear: assert property (p_fresh_clear) // RULE_04
    else $error("fresh flag not cleared after high byte read");

  property p_narrow_layout;
    @(posedge mclk) disable iff (rst)
      (load && !load_voltage) |=> (hi_byte[6:5] == 2'b00)
        && (hi_byte[4:0] == $past(load_data[12:8]));
  endproperty
  a_narrow_layout: assert property (p_narrow_layout) // RULE_01
    else $error("narrow high byte layout wrong");

  property p_voltage_layout;
    @(posedge mclk) disable iff (rst)
      (load && load_voltage) |=> (hi_byte[`BIT_SIGN] == $past(load_sign))
        && (hi_byte[5:0] == $past(load_data[13:8]));
  endproperty
  a_voltage_layout: assert property (p_voltage_layout) // RULE_11
    else $error("voltage high byte layout wrong");

  property p_low_layout;
    @(posedge mclk) disable iff (rst) load |=> lo_byte == $past(load_data[7:0]);
  endproperty
  a_low_layout: assert property (p_low_layout) // RULE_02
    else $error("low byte does not hold result bits 7 to 0");

endmodule // result_slot

`default_nettype wire

// *** logic/monitor_regs.sv ***
// Result and threshold register bank of the voltage, current and temperature monitor
//
// Operation
// [RULE_01] Diode high byte: fresh flag bit 7, bits 6:5 unused, result bits 12:8.
// [RULE_02] Low byte carries result bits 7 down to 0, MSB first.
// [RULE_03] Storing a new result sets the fresh flag of its high byte.
// [RULE_04] Reading a high byte clears its fresh flag.
// [RULE_05] Threshold upper register holds threshold bits 8 down to 1.
// [RULE_06] Single-ended voltages: signed 14 bits, 305.18 uV per step, two's complement.
// [RULE_07] Differential voltages: signed 14 bits, 19.075 uV per step.
// [RULE_08] Supply result is offset from 2.5 V at 305.18 uV per step.
// [RULE_09] Temperatures: 13 bits, 0.0625 degree per step, Celsius or Kelvin.
// [RULE_10] Remote diode voltages coded at 38.15 uV per step.
// [RULE_11] Voltage high byte: fresh flag bit 7, sign bit 6, result bits 13:8.
// [RULE_12] Threshold bit 0 sits in MSB of the control register.
// [RULE_13] High and low byte read back to back come from one conversion.
`include "monitor_regs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module monitor_regs #(
  parameter int NUM_SLOTS = `NUM_RESULT_SLOTS  // Result register pairs
) (
  input  wire logic                       mclk,          // System clock, 20 MHz
  input  wire logic                       rst,           // Async reset, active high
  input  wire monitor_regs_pkg::reg_req_t req,           // Register access from serial engine
  input  wire monitor_regs_pkg::conv_in_t conv,          // Finished conversion
  output logic      [7:0]                 rd_data,       // Read data, registered
  output logic                            rd_valid,      // Read data valid pulse
  output logic      [8:0]                 pwm_threshold, // Full threshold value
  output logic      [4:0]                 ctrl_flags     // Control bits 6:2
);

  monitor_regs_pkg::top_state_t st_r;
  monitor_regs_pkg::top_state_t st_nxt;

  logic [NUM_SLOTS-1:0] rd_hi_vec;
  logic [7:0]           hi_b [NUM_SLOTS];
  logic [7:0]           lo_b [NUM_SLOTS];
  logic [7:0]           rel;
  logic [`SLOT_IDX_W-1:0] sel;
  logic                 in_range;
  logic                 is_lo;

  assign rel      = req.addr - `OFS_RESULT_BASE;
  assign sel      = rel[`SLOT_IDX_W:1];
  assign is_lo    = rel[0];
  assign in_range = (req.addr >= `OFS_RESULT_BASE) && (rel < 8'(2 * NUM_SLOTS));

  genvar i;
  generate
    for (i = 0; i < NUM_SLOTS; i = i + 1) begin : g_slot
      assign rd_hi_vec[i] = req.rd && in_range && !is_lo && (sel == `SLOT_IDX_W'(i)); // RULE_04
      result_slot u_slot (
        .mclk         (mclk),
        .rst          (rst),
        .load         (conv.valid && (conv.slot == `SLOT_IDX_W'(i))), // RULE_03
        .load_voltage (conv.voltage),
        .load_sign    (conv.sign),
        .load_data    (conv.data),
        .rd_hi        (rd_hi_vec[i]),
        .hi_byte      (hi_b[i]),
        .lo_byte      (lo_b[i])
      );
    end
  endgenerate

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = req.rd;
    if (req.wr) begin
      case (req.addr)
        `OFS_CTRL: begin
          st_nxt.ctrl = req.wdata & `CTRL_RW_MASK; // RULE_12
        end
        `OFS_PWM_UPPER: begin
          st_nxt.pwm_upper = req.wdata; // RULE_05
        end
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      st_nxt.rd_data = 8'h00;
      if (in_range) begin
        if (!is_lo) begin
          st_nxt.rd_data     = hi_b[sel];
          st_nxt.lo_shadow   = lo_b[sel]; // RULE_13
          st_nxt.shadow_slot = sel;
          st_nxt.shadow_ok   = 1'b1;
        end else if (st_r.shadow_ok && st_r.shadow_slot == sel) begin
          st_nxt.rd_data   = st_r.lo_shadow; // RULE_13
          st_nxt.shadow_ok = 1'b0;
        end else begin
          st_nxt.rd_data = lo_b[sel];
        end
      end else begin
        case (req.addr)
          `OFS_CTRL:      st_nxt.rd_data = st_r.ctrl;
          `OFS_PWM_UPPER: st_nxt.rd_data = st_r.pwm_upper;
          default:        st_nxt.rd_data = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.ctrl      <= `CTRL_RESET;
      st_r.pwm_upper <= `PWM_UPPER_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data       = st_r.rd_data;
  assign rd_valid      = st_r.rd_valid;
  assign pwm_threshold = {st_r.pwm_upper, st_r.ctrl[`BIT_PWM_LSB]}; // RULE_05 RULE_12
  assign ctrl_flags    = st_r.ctrl[6:2];

  property p_pwm_upper;
    @(posedge mclk) disable iff (rst)
      (req.wr && req.addr == `OFS_PWM_UPPER) |=> pwm_threshold[8:1] == $past(req.wdata);
  endproperty
  a_pwm_upper: assert property (p_pwm_upper) // RULE_05
    else $error("threshold bits 8 to 1 not taken from upper register");

  property p_pwm_lsb;
    @(posedge mclk) disable iff (rst)
      (req.wr && req.addr == `OFS_CTRL) |=> pwm_threshold[0] == $past(req.wdata[7]);
  endproperty
  a_pwm_lsb: assert property (p_pwm_lsb) // RULE_12
    else $error("threshold bit 0 not taken from control MSB");

  property p_coherent_pair;
    @(posedge mclk) disable iff (rst)
      (req.rd && in_range && !is_lo)
        ##1 (req.rd && in_range && is_lo && sel == $past(sel))
        |=> rd_data == $past(lo_b[sel], 2);
  endproperty
  a_coherent_pair: assert property (p_coherent_pair) // RULE_13
    else $error("low byte not from same conversion as high byte");

  property p_read_answer;
    @(posedge mclk) disable iff (rst) req.rd |=> rd_valid ##1 !rd_valid || $past(req.rd);
  endproperty
  a_read_answer: assert property (p_read_answer) // RULE_04
    else $error("read not answered one cycle later");

  property p_high_read_data;
    @(posedge mclk) disable iff (rst)
      (req.rd && in_range && !is_lo) |=> rd_data == $past(hi_b[sel]);
  endproperty
  a_high_read_data: assert property (p_high_read_data) // RULE_01
    else $error("high byte read returned wrong value");

  property p_live_low_read;
    @(posedge mclk) disable iff (rst)
      (req.rd && in_range && is_lo && !(st_r.shadow_ok && st_r.shadow_slot == sel))
        |=> rd_data == $past(lo_b[sel]);
  endproperty
  a_live_low_read: assert property (p_live_low_read) // RULE_02
    else $error("unpaired low byte read not live");

  property p_shadow_capture;
    @(posedge mclk) disable iff (rst)
      (req.rd && in_range && !is_lo)
        |=> st_r.shadow_ok && (st_r.lo_shadow == $past(lo_b[sel]));
  endproperty
  a_shadow_capture: assert property (p_shadow_capture) // RULE_13
    else $error("low byte not latched on high byte read");

  property p_shadow_one_shot;
    @(posedge mclk) disable iff (rst)
      (req.rd && in_range && is_lo && st_r.shadow_ok && st_r.shadow_slot == sel)
        |=> !st_r.shadow_ok;
  endproperty
  a_shadow_one_shot: assert property (p_shadow_one_shot) // RULE_13
    else $error("latched low byte used more than once");

  property p_fresh_cleared_top;
    @(posedge mclk) disable iff (rst)
      (req.rd && in_range && !is_lo && !(conv.valid && conv.slot == sel))
        |=> !hi_b[$past(sel)][`BIT_FRESH];
  endproperty
  a_fresh_cleared_top: assert property (p_fresh_cleared_top) // RULE_04
    else $error("fresh flag still set after high byte read");

  property p_fresh_set_top;
    @(posedge mclk) disable iff (rst)
      (conv.valid && conv.slot < `SLOT_IDX_W'(NUM_SLOTS))
        |=> hi_b[$past(conv.slot)][`BIT_FRESH];
  endproperty
  a_fresh_set_top: assert property (p_fresh_set_top) // RULE_03
    else $error("fresh flag not set in addressed slot");

  property p_ctrl_read_lsb;
    @(posedge mclk) disable iff (rst)
      (req.rd && req.addr == `OFS_CTRL) |=> rd_data[`BIT_PWM_LSB] == $past(pwm_threshold[0]);
  endproperty
  a_ctrl_read_lsb: assert property (p_ctrl_read_lsb) // RULE_12
    else $error("control MSB does not read back threshold bit 0");

  property p_pwm_upper_read;
    @(posedge mclk) disable iff (rst)
      (req.rd && req.addr == `OFS_PWM_UPPER) |=> rd_data == $past(pwm_threshold[8:1]);
  endproperty
  a_pwm_upper_read: assert property (p_pwm_upper_read) // RULE_05
    else $error("upper register does not read back threshold bits 8 to 1");

  property p_pwm_hold;
    @(posedge mclk) disable iff (rst) !req.wr |=> $stable(pwm_threshold);
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) // RULE_05
    else $error("threshold changed without a write");

  property p_ctrl_flags;
    @(posedge mclk) disable iff (rst)
      (req.wr && req.addr == `OFS_CTRL) |=> ctrl_flags == $past(req.wdata[6:2]);
  endproperty
  a_ctrl_flags: assert property (p_ctrl_flags) // RULE_12
    else $error("control bits 6 to 2 not taken from write");

  property p_valid_after_read;
    @(posedge mclk) disable iff (rst) rd_valid |-> $past(req.rd);
  endproperty
  a_valid_after_read: assert property (p_valid_after_read) // RULE_04
    else $error("read data valid without a read");

endmodule // monitor_regs

`default_nettype wire

// *** tb/reg_host.sv ***
// Register host model issuing single-byte reads and writes
`timescale 1ns/1ns
`default_nettype none

module reg_host (
  input  wire logic                  mclk,     // System clock
  output monitor_regs_pkg::reg_req_t req,      // Request toward the bank
  input  wire logic [7:0]            rd_data,  // Read data
  input  wire logic                  rd_valid  // Read data valid
);
  initial req = '0;

  // Idle address and data show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Missing valid pulse returns 1FF
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    #1 d = (rd_valid === 1'b1) ? {1'b0, rd_data} : 9'h1FF;
  endtask

  // Two reads back to back, strobe held high between them
  task automatic rd2(input logic [7:0] a, input logic [7:0] b,
                     output logic [8:0] d1, output logic [8:0] d2);
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: b, wdata: 8'h00};
    #1 d1 = (rd_valid === 1'b1) ? {1'b0, rd_data} : 9'h1FF;
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~b, wdata: 8'hFF};
    #1 d2 = (rd_valid === 1'b1) ? {1'b0, rd_data} : 9'h1FF;
  endtask
endmodule // reg_host

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the monitor result register bank
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic                       mclk;
  logic                       rst;
  monitor_regs_pkg::reg_req_t req;
  monitor_regs_pkg::conv_in_t conv;
  logic [7:0]                 rd_data;
  logic                       rd_valid;
  logic [8:0]                 pwm_threshold;
  logic [4:0]                 ctrl_flags;
  logic [8:0]                 got;
  int                         err_total;
  int                         num_checks;
  int                         cycles;

  monitor_regs dut (.mclk(mclk), .rst(rst), .req(req), .conv(conv), .rd_data(rd_data),
    .rd_valid(rd_valid), .pwm_threshold(pwm_threshold), .ctrl_flags(ctrl_flags));
  reg_host host (.mclk(mclk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles > 2000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk(got, {1'b0, e});
  endtask

  task automatic load(input logic [3:0] s, input logic v, input logic sg, input logic [13:0] d);
    @(posedge mclk);
    conv <= '{valid: 1'b1, slot: s, voltage: v, sign: sg, data: d};
    @(posedge mclk);
    conv <= '{valid: 1'b0, slot: ~s, voltage: ~v, sign: ~sg, data: ~d};
  endtask

  task automatic t_reset_and_ctrl();
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    host.wr(8'h08, 8'hFF);
    host.wr(8'h09, 8'hA5);
    #1 chk(pwm_threshold, 9'h14B);
    chk({4'h0, ctrl_flags}, 9'h01F);
    rchk(8'h08, 8'hFC);
    rchk(8'h09, 8'hA5);
  endtask

  task automatic t_wide_result();
    load(4'h0, 1'b1, 1'b1, 14'h2A5C);
    host.wr(8'h0A, 8'h00);
    rchk(8'h0A, 8'hEA);
    rchk(8'h0B, 8'h5C);
    rchk(8'h0A, 8'h6A);
  endtask

  task automatic t_narrow_and_coherence();
    load(4'h3, 1'b0, 1'b0, 14'h1F3C);
    rchk(8'h10, 8'h9F);
    load(4'h3, 1'b0, 1'b0, 14'h0102);
    rchk(8'h11, 8'h3C);
    rchk(8'h11, 8'h02);
    rchk(8'h10, 8'h81);
    rchk(8'h10, 8'h01);
  endtask

  task automatic t_unmapped();
    load(4'hA, 1'b1, 1'b0, 14'h3FFF);
    rchk(8'h1E, 8'h00);
    rchk(8'h1C, 8'h00);
  endtask

  // Result lands on the edge of the high byte read, low byte read right after
  task automatic t_shadow_race();
    logic [8:0] d2;
    load(4'h5, 1'b1, 1'b0, 14'h0123);
    fork
      load(4'h5, 1'b1, 1'b1, 14'h3E45);
      host.rd2(8'h14, 8'h15, got, d2);
    join
    chk(got, 9'h081);
    chk(d2, 9'h023);
    rchk(8'h15, 8'h45);
    rchk(8'h14, 8'hFE);
    rchk(8'h14, 8'h7E);
  endtask

  // Reset in mid-run clears results and threshold
  task automatic t_mid_reset();
    host.wr(8'h09, 8'h5A);
    load(4'h1, 1'b0, 1'b0, 14'h0ABC);
    rchk(8'h0C, 8'h8A);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(pwm_threshold, 9'h000);
    chk({4'h0, ctrl_flags}, 9'h000);
    rchk(8'h0C, 8'h00);
    rchk(8'h0D, 8'h00);
    rchk(8'h09, 8'h00);
  endtask

  initial begin
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    conv = '0;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset_and_ctrl();
    t_wide_result();
    t_narrow_and_coherence();
    t_unmapped();
    t_shadow_race();
    t_mid_reset();
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
